// ===== src/canes_pkg.sv
// Constants, register map and types of the CAN error and status block.
// Assumes one 100 MHz clock shared with the protocol engine and the AHB-Lite bus.
// Contract
// - Writes to the error count register change nothing.
// - Error count register shows the live transmit and receive error counters.
// - Soft reset or core enable written zero clears both counters.
// - Entering bus off clears both counters.
// - In bus off, each run of 11 recessive bits adds one to receive count.
// - After 128 such runs go error active and clear both counters.
// - Receive count at bits 16-23, transmit count at 24-31, others zero.
// - Several errors at once set every matching flag.
// - Flag writes never set; writing one clears; flags otherwise sticky.
// - Core enable written zero clears all error flags.
// - Flags at 27 ack, 28 bit, 29 stuff, 30 form, 31 crc.
// - Acknowledge error sets the ack flag.
// - Sampled bit differing from transmitted bit sets the bit flag.
// - Stuff violation sets stuff flag; fixed-form field error sets form flag.
// - CRC error with corrupt delimiter sets form flag only.
// - Status bits: filter busy 20, tx full 21, priority full 22, state 23-24.
// - Filter busy set when a filter use bit is written zero.
// - Filter busy exists only with a nonzero filter count.
// - Tx queue full reads one exactly while the transmit FIFO has no room.
// - Priority slot full reads one while the priority buffer is occupied.
// - State field 00 config, 01 active, 11 passive, 10 bus off.
// - Warning reads one when either counter is at least 96.
// - Configuration indicator reads one in configuration mode, resets to one.
// - Soft reset returns control register to default; soft reset bit reads zero.
package canes_pkg;

  // Byte addresses on the register bus.
  localparam logic [7:0] CANES_SOFT_RESET_CONTROL_REG = 8'h00;
  localparam logic [7:0] CANES_ERROR_COUNT_REG        = 8'h10;
  localparam logic [7:0] CANES_ERROR_FLAG_REG         = 8'h14;
  localparam logic [7:0] CANES_CORE_STATE_REG         = 8'h18;

  // Documented bit n sits at hardware index 31-n.
  // msb-first numbering
  localparam int CANES_SOFT_RESET_BIT  = 0;
  localparam int CANES_CORE_ENABLE_BIT = 1;
  localparam int CANES_RX_COUNT_LSB    = 8;
  localparam int CANES_TX_COUNT_LSB    = 0;
  localparam int CANES_ACK_FLAG_BIT    = 4;
  localparam int CANES_BIT_FLAG_BIT    = 3;
  localparam int CANES_STUFF_FLAG_BIT  = 2;
  localparam int CANES_FORM_FLAG_BIT   = 1;
  localparam int CANES_CRC_FLAG_BIT    = 0;
  localparam int CANES_FILTER_BUSY_BIT = 11;
  localparam int CANES_TX_FULL_BIT     = 10;
  localparam int CANES_PRIO_FULL_BIT   = 9;
  localparam int CANES_FCS_LSB         = 7;
  localparam int CANES_WARNING_BIT     = 6;
  localparam int CANES_BUS_BUSY_BIT    = 5;
  localparam int CANES_BUS_IDLE_BIT    = 4;
  localparam int CANES_NORMAL_BIT      = 3;
  localparam int CANES_SLEEP_BIT       = 2;
  localparam int CANES_LOOPBACK_BIT    = 1;
  localparam int CANES_CONFIG_BIT      = 0;

  localparam logic [7:0] CANES_COUNT_RESET   = 8'h00;
  localparam logic [4:0] CANES_FLAGS_RESET   = 5'h00;
  localparam logic [7:0] CANES_WARN_LEVEL    = 8'h60;
  localparam logic [7:0] CANES_PASSIVE_LEVEL = 8'h80;
  localparam logic [7:0] CANES_RECOVER_LAST  = 8'h7F;
  localparam logic [3:0] CANES_RUN_LAST      = 4'hA;
  localparam int         CANES_NUM_FILTERS   = 4;

  localparam logic [1:0] CANES_FCS_CONFIG  = 2'h0;
  localparam logic [1:0] CANES_FCS_ACTIVE  = 2'h1;
  localparam logic [1:0] CANES_FCS_PASSIVE = 2'h3;
  localparam logic [1:0] CANES_FCS_BUSOFF  = 2'h2;

  typedef enum logic [1:0] {
    CANES_ST_CONFIG,
    CANES_ST_ACTIVE,
    CANES_ST_PASSIVE,
    CANES_ST_BUSOFF
  } canes_state_t;

endpackage

// ===== src/canes_top.sv
// Error counters, error type flags and core status of a CAN controller, with an AHB-Lite slave.
// Assumes the protocol engine and the bus master share hclk; engine inputs are synchronous.
`timescale 1ns/10ps
module canes_top
  import canes_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        tx_err_add8,
  input  wire logic        tx_ok_sub1,
  input  wire logic        rx_err_add1,
  input  wire logic        rx_err_add8,
  input  wire logic        rx_ok_sub1,
  input  wire logic        sample_strobe,
  input  wire logic        sampled_bit,
  input  wire logic        tx_active,
  input  wire logic        tx_bit,
  input  wire logic        ack_error,
  input  wire logic        stuff_error,
  input  wire logic        form_error,
  input  wire logic        crc_error,
  input  wire logic        crc_delim_error,
  input  wire logic        filter_use_cleared,
  input  wire logic        filter_update_done,
  input  wire logic        tx_fifo_full,
  input  wire logic        prio_buf_full,
  input  wire logic        bus_busy,
  input  wire logic        bus_idle,
  input  wire logic        normal_mode,
  input  wire logic        sleep_mode,
  input  wire logic        loopback_mode,
  output logic             core_enable,
  output logic             filter_update_pending,
  output logic [1:0]       fault_confinement_state
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so that the captured word already holds any
  // write that completed at the edge which took the read address.
  logic       aph_take;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic       hreadyout_q;
  logic       hresp_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata_d;
  logic       wr_ctrl;
  logic       wr_flags;
  logic       sw_reset;
  logic       ena_clear;

  assign aph_take  = hsel && htrans[1] && hready;
  assign wr_ctrl   = wr_pend_q && (wr_addr_q == CANES_SOFT_RESET_CONTROL_REG);
  assign wr_flags  = wr_pend_q && (wr_addr_q == CANES_ERROR_FLAG_REG);
  assign sw_reset  = wr_ctrl && hwdata[CANES_SOFT_RESET_BIT];
  assign ena_clear = wr_ctrl && !hwdata[CANES_CORE_ENABLE_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= aph_take && hwrite;
      if (aph_take) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
        rd_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      hreadyout_q <= !(aph_take && !hwrite);
      hresp_q     <= 1'b0;
      if (!hreadyout_q) begin
        hrdata_q <= rdata_d;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // ----------------------------------------------------------------
  // Soft reset control register
  // ----------------------------------------------------------------
  logic ena_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ena_q <= 1'b0;
    end else if (sw_reset) begin
      ena_q <= 1'b0;
    end else if (wr_ctrl) begin
      ena_q <= hwdata[CANES_CORE_ENABLE_BIT];
    end
  end

  assign core_enable = ena_q;

  // ----------------------------------------------------------------
  // Error counters and fault confinement
  // ----------------------------------------------------------------
  canes_state_t state_q;
  canes_state_t state_d;
  logic [7:0]   txc_q;
  logic [7:0]   txc_d;
  logic [7:0]   rxc_q;
  logic [7:0]   rxc_d;
  logic [3:0]   run_cnt_q;
  logic         run11;
  logic [8:0]   txc_sum;
  logic [8:0]   rxc_sum;

  assign run11 = (state_q == CANES_ST_BUSOFF) && sample_strobe && sampled_bit
                 && (run_cnt_q == CANES_RUN_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt_q <= 4'h0;
    end else if (state_q != CANES_ST_BUSOFF) begin
      run_cnt_q <= 4'h0;
    end else if (sample_strobe) begin
      run_cnt_q <= (!sampled_bit || run11) ? 4'h0 : run_cnt_q + 4'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    txc_d   = txc_q;
    rxc_d   = rxc_q;
    txc_sum = {1'b0, txc_q};
    rxc_sum = {1'b0, rxc_q};
    if (tx_err_add8) begin
      txc_sum = txc_sum + 9'h008;
    end else if (tx_ok_sub1 && (txc_q != 8'h00)) begin
      txc_sum = txc_sum - 9'h001;
    end
    if (rx_err_add8) begin
      rxc_sum = rxc_sum + 9'h008;
    end else if (rx_err_add1) begin
      rxc_sum = rxc_sum + 9'h001;
    end else if (rx_ok_sub1 && (rxc_q != 8'h00)) begin
      rxc_sum = rxc_sum - 9'h001;
    end
    if (rxc_sum[8]) begin
      rxc_sum = 9'h0FF;
    end
    unique case (state_q)
      CANES_ST_CONFIG: begin
        if (ena_q) begin
          state_d = CANES_ST_ACTIVE;
        end
      end
      CANES_ST_ACTIVE, CANES_ST_PASSIVE: begin
        if (txc_sum[8]) begin
          state_d = CANES_ST_BUSOFF;
          txc_d   = CANES_COUNT_RESET;
          rxc_d   = CANES_COUNT_RESET;
        end else begin
          txc_d   = txc_sum[7:0];
          rxc_d   = rxc_sum[7:0];
          state_d = ((txc_d >= CANES_PASSIVE_LEVEL) || (rxc_d >= CANES_PASSIVE_LEVEL))
                    ? CANES_ST_PASSIVE : CANES_ST_ACTIVE;
        end
      end
      CANES_ST_BUSOFF: begin
        if (run11) begin
          if (rxc_q == CANES_RECOVER_LAST) begin
            state_d = CANES_ST_ACTIVE;
            txc_d   = CANES_COUNT_RESET;
            rxc_d   = CANES_COUNT_RESET;
          end else begin
            rxc_d = rxc_q + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CANES_ST_CONFIG;
      txc_q   <= CANES_COUNT_RESET;
      rxc_q   <= CANES_COUNT_RESET;
    end else if (sw_reset || ena_clear) begin
      state_q <= CANES_ST_CONFIG;
      txc_q   <= CANES_COUNT_RESET;
      rxc_q   <= CANES_COUNT_RESET;
    end else begin
      state_q <= state_d;
      txc_q   <= txc_d;
      rxc_q   <= rxc_d;
    end
  end

  logic [1:0] fcs_code;

  always_comb begin
    unique case (state_q)
      CANES_ST_CONFIG:  fcs_code = CANES_FCS_CONFIG;
      CANES_ST_ACTIVE:  fcs_code = CANES_FCS_ACTIVE;
      CANES_ST_PASSIVE: fcs_code = CANES_FCS_PASSIVE;
      CANES_ST_BUSOFF:  fcs_code = CANES_FCS_BUSOFF;
    endcase
  end

  logic [1:0] fcs_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcs_q <= CANES_FCS_CONFIG;
    end else begin
      fcs_q <= fcs_code;
    end
  end

  assign fault_confinement_state = fcs_q;

  // ----------------------------------------------------------------
  // Error type flags
  // ----------------------------------------------------------------
  logic [4:0] flags_q;
  logic [4:0] flag_set;
  logic       bit_mismatch;

  assign bit_mismatch = sample_strobe && tx_active && (sampled_bit != tx_bit);

  always_comb begin
    flag_set                       = 5'h00;
    flag_set[CANES_ACK_FLAG_BIT]   = ack_error;
    flag_set[CANES_BIT_FLAG_BIT]   = bit_mismatch;
    flag_set[CANES_STUFF_FLAG_BIT] = stuff_error;
    flag_set[CANES_FORM_FLAG_BIT]  = form_error || crc_delim_error;
    flag_set[CANES_CRC_FLAG_BIT]   = crc_error && !crc_delim_error;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= CANES_FLAGS_RESET;
    end else if (sw_reset || ena_clear) begin
      flags_q <= CANES_FLAGS_RESET;
    end else if (wr_flags) begin
      flags_q <= (flags_q & ~hwdata[4:0]) | flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // Filter busy
  // ----------------------------------------------------------------
  logic fbusy_q;

  generate
    if (CANES_NUM_FILTERS != 0) begin : g_fbusy
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fbusy_q <= 1'b0;
        end else if (filter_use_cleared) begin
          fbusy_q <= 1'b1;
        end else if (filter_update_done) begin
          fbusy_q <= 1'b0;
        end
      end
    end else begin : g_nofbusy
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fbusy_q <= 1'b0;
        end else begin
          fbusy_q <= 1'b0;
        end
      end
    end
  endgenerate

  assign filter_update_pending = fbusy_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (rd_addr_q)
      CANES_SOFT_RESET_CONTROL_REG: begin
        rdata_d[CANES_CORE_ENABLE_BIT] = ena_q;
      end
      CANES_ERROR_COUNT_REG: begin
        rdata_d[CANES_RX_COUNT_LSB +: 8] = rxc_q;
        rdata_d[CANES_TX_COUNT_LSB +: 8] = txc_q;
      end
      CANES_ERROR_FLAG_REG: begin
        rdata_d[4:0] = flags_q;
      end
      CANES_CORE_STATE_REG: begin
        rdata_d[CANES_FILTER_BUSY_BIT] = fbusy_q;
        rdata_d[CANES_TX_FULL_BIT]     = tx_fifo_full;
        rdata_d[CANES_PRIO_FULL_BIT]   = prio_buf_full;
        rdata_d[CANES_FCS_LSB +: 2]    = fcs_code;
        rdata_d[CANES_WARNING_BIT]     = (txc_q >= CANES_WARN_LEVEL)
                                         || (rxc_q >= CANES_WARN_LEVEL);
        rdata_d[CANES_BUS_BUSY_BIT]    = bus_busy;
        rdata_d[CANES_BUS_IDLE_BIT]    = bus_idle;
        rdata_d[CANES_NORMAL_BIT]      = normal_mode;
        rdata_d[CANES_SLEEP_BIT]       = sleep_mode;
        rdata_d[CANES_LOOPBACK_BIT]    = loopback_mode;
        rdata_d[CANES_CONFIG_BIT]      = (state_q == CANES_ST_CONFIG);
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic engine_quiet;
  assign engine_quiet = !(tx_err_add8 || tx_ok_sub1 || rx_err_add1 || rx_err_add8
                          || rx_ok_sub1 || run11);

  AST_COUNT_READ_ONLY: assert property (
    (wr_pend_q && wr_addr_q == CANES_ERROR_COUNT_REG && engine_quiet
     && state_q != CANES_ST_CONFIG) |=> $stable(txc_q) && $stable(rxc_q))
    else $error("error count write changed a counter");

  AST_SW_CLEAR: assert property (
    (sw_reset || ena_clear) |=> txc_q == 8'h00 && rxc_q == 8'h00
                                && state_q == CANES_ST_CONFIG)
    else $error("software clear left counters nonzero");

  AST_BUSOFF_ZERO: assert property (
    (state_q != CANES_ST_BUSOFF) ##1 (state_q == CANES_ST_BUSOFF)
    |-> txc_q == 8'h00 && rxc_q == 8'h00)
    else $error("bus off entered with nonzero counters");

  AST_RUN_STEP: assert property (
    (run11 && rxc_q != CANES_RECOVER_LAST && !sw_reset && !ena_clear)
    |=> rxc_q == $past(rxc_q) + 8'h01)
    else $error("recessive run did not advance receive count");

  AST_RECOVER: assert property (
    (run11 && rxc_q == CANES_RECOVER_LAST && !sw_reset && !ena_clear)
    |=> state_q == CANES_ST_ACTIVE && txc_q == 8'h00 && rxc_q == 8'h00)
    else $error("recovery did not return to error active");

  AST_FLAG_NO_SW_SET: assert property (
    $rose(flags_q[CANES_ACK_FLAG_BIT]) |-> $past(ack_error))
    else $error("ack flag rose without an ack error");

  AST_FLAG_W1C: assert property (
    (wr_flags && hwdata[CANES_STUFF_FLAG_BIT] && !stuff_error && !ena_clear)
    |=> !flags_q[CANES_STUFF_FLAG_BIT])
    else $error("write one did not clear stuff flag");

  AST_DISABLE_FLAGS: assert property (
    ena_clear |=> flags_q == 5'h00)
    else $error("core disable left flags set");

  AST_CRC_DELIM: assert property (
    (crc_error && crc_delim_error && !flags_q[CANES_CRC_FLAG_BIT] && !ena_clear
     && !sw_reset) |=> !flags_q[CANES_CRC_FLAG_BIT] && flags_q[CANES_FORM_FLAG_BIT])
    else $error("crc flag set despite corrupt delimiter");

  AST_TX_FULL_READ: assert property (
    (!hreadyout_q && rd_addr_q == CANES_CORE_STATE_REG)
    |=> hrdata_q[CANES_TX_FULL_BIT] == $past(tx_fifo_full) && hreadyout_q)
    else $error("tx queue full bit does not follow the FIFO");

  AST_SOFT_RESET_DEFAULT: assert property (
    sw_reset |=> !ena_q)
    else $error("soft reset left core enabled");

  AST_CTRL_READ_ZERO: assert property (
    (!hreadyout_q && rd_addr_q == CANES_SOFT_RESET_CONTROL_REG)
    |=> !hrdata_q[CANES_SOFT_RESET_BIT])
    else $error("soft reset bit read back as one");

  COV_BUSOFF: cover property (state_q == CANES_ST_ACTIVE ##1 state_q == CANES_ST_BUSOFF);
  COV_RECOVER: cover property (state_q == CANES_ST_BUSOFF ##1 state_q == CANES_ST_ACTIVE);
  COV_PASSIVE: cover property (state_q == CANES_ST_PASSIVE);
  COV_FLAG_CLEAR: cover property (wr_flags && flags_q != 5'h00 ##1 flags_q == 5'h00);

endmodule

// ===== tb/can_error_status_tb.sv
// Self-checking bench of the CAN error and status block, reads checked from a queue.
// Assumes an AHB-Lite slave with hready tied to hreadyout and one 100 MHz clock.
`timescale 1ns/10ps
module can_error_status_tb;
  import canes_pkg::*;
  localparam logic [11:0] E_TX8 = 12'h001, E_TXS = 12'h002, E_RX1 = 12'h004, E_RX8 = 12'h008;
  localparam logic [11:0] E_RXS = 12'h010, E_ACK = 12'h020, E_STF = 12'h040, E_FRM = 12'h080;
  localparam logic [11:0] E_CRC = 12'h100, E_DLM = 12'h200, E_FUC = 12'h400, E_FUD = 12'h800;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, core_enable, fup, rd_dp;
  logic        sample_strobe, sampled_bit, tx_active, tx_bit, cfg, fb;
  logic [7:0]  haddr, txc, rxc;
  logic [1:0]  htrans, fcs, fs;
  logic [31:0] hwdata, hrdata;
  logic [11:0] ev;
  logic [6:0]  lv;
  logic [31:0] exp_q[$];
  int          mismatches, tests_run, k;

  canes_top canes_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_err_add8(ev[0]),
    .tx_ok_sub1(ev[1]), .rx_err_add1(ev[2]), .rx_err_add8(ev[3]), .rx_ok_sub1(ev[4]),
    .sample_strobe(sample_strobe), .sampled_bit(sampled_bit), .tx_active(tx_active),
    .tx_bit(tx_bit), .ack_error(ev[5]), .stuff_error(ev[6]), .form_error(ev[7]),
    .crc_error(ev[8]), .crc_delim_error(ev[9]), .filter_use_cleared(ev[10]),
    .filter_update_done(ev[11]), .tx_fifo_full(lv[6]), .prio_buf_full(lv[5]),
    .bus_busy(lv[4]), .bus_idle(lv[3]), .normal_mode(lv[2]), .sleep_mode(lv[1]),
    .loopback_mode(lv[0]), .core_enable(core_enable), .filter_update_pending(fup),
    .fault_confinement_state(fcs));
  canes_engine_model canes_engine_model_inst (.hclk(hclk), .ev(ev),
    .sample_strobe(sample_strobe), .sampled_bit(sampled_bit), .tx_active(tx_active),
    .tx_bit(tx_bit), .lv(lv));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data is taken at the edge that ends the data phase, before the slave updates.
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      cmp(hrdata, exp_q.pop_front());
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= w ? d : $urandom;
    if (!w) begin
      exp_q.push_back(d);
      rd_dp <= 1'b1;
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask

  function automatic logic [31:0] cntw();
    return {16'h0000, rxc, txc};
  endfunction

  // Core enable is expected high exactly while the state is not configuration.
  task automatic rd_stat();
    canes_engine_model_inst.setlv();
    xfer(1'b0, CANES_CORE_STATE_REG,
         {20'h0, fb, lv[6:5], fs, (txc >= CANES_WARN_LEVEL || rxc >= CANES_WARN_LEVEL),
          lv[4:0], cfg});
    cmp({27'h0, hresp, core_enable, fup, fcs}, {27'h0, 1'b0, !cfg, fb, fs});
  endtask

  task automatic fire(input logic [11:0] m, input int n);
    canes_engine_model_inst.fire(m, n);
  endtask

  task automatic bits(input int n, input logic v, input logic drv, input logic txb);
    canes_engine_model_inst.bits(n, v, drv, txb);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The longest path is bus off recovery, about 3000 cycles; the limit leaves ample room.
  initial begin
    #200000;
    mismatches++;
    $display("Watchdog expired at %0t", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    mismatches = 0;
    tests_run = 0;
    {txc, rxc, fs, cfg, fb} = {8'h00, 8'h00, CANES_FCS_CONFIG, 1'b1, 1'b0};
    void'($urandom(32'hDE898EF7));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h0);
    rd_stat();
    $display("test reset done");
    xfer(1'b1, CANES_SOFT_RESET_CONTROL_REG, 32'h2);
    {fs, cfg} = {CANES_FCS_ACTIVE, 1'b0};
    xfer(1'b0, CANES_SOFT_RESET_CONTROL_REG, 32'h2);
    rd_stat();
    k = $urandom_range(9, 1);
    fire(E_TX8, k);
    txc = 8'(8 * k);
    k = $urandom_range(20, 1);
    fire(E_RX1, k);
    rxc = 8'(k - 1);
    txc = txc - 8'h01;
    fire(E_TXS | E_RXS, 1);
    xfer(1'b1, CANES_ERROR_COUNT_REG, $urandom);
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    xfer(1'b1, CANES_CORE_STATE_REG, $urandom);
    rd_stat();
    $display("test counters done");
    fire(E_RX1, 95 - int'(rxc));
    rxc = 8'd95;
    rd_stat();
    fire(E_RX1, 1);
    rxc = 8'd96;
    rd_stat();
    fire(E_RX8, 4);
    {rxc, fs} = {8'd128, CANES_FCS_PASSIVE};
    rd_stat();
    $display("test warning done");
    fire(E_TX8, (255 - int'(txc)) / 8 + 1);
    {txc, rxc, fs} = {8'h00, 8'h00, CANES_FCS_BUSOFF};
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    rd_stat();
    bits(10, 1'b1, 1'b0, 1'b1);
    bits(1, 1'b0, 1'b0, 1'b1);
    bits(10, 1'b1, 1'b0, 1'b1);
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    bits(1, 1'b1, 1'b0, 1'b1);
    rxc = 8'd1;
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    bits(11 * 126, 1'b1, 1'b0, 1'b1);
    rxc = 8'd127;
    rd_stat();
    bits(11, 1'b1, 1'b0, 1'b1);
    {rxc, fs} = {8'h00, CANES_FCS_ACTIVE};
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    rd_stat();
    $display("test bus off done");
    bits(1, 1'b0, 1'b1, 1'b1);
    fire(E_ACK | E_STF | E_FRM | E_CRC, 1);
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h1F);
    xfer(1'b1, CANES_ERROR_FLAG_REG, 32'h0);
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h1F);
    k = $urandom_range(31, 0);
    xfer(1'b1, CANES_ERROR_FLAG_REG, 32'(k));
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h1F & ~32'(k));
    xfer(1'b1, CANES_ERROR_FLAG_REG, 32'h1F);
    fire(E_CRC | E_DLM, 1);
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h02);
    fire(E_TX8, 2);
    xfer(1'b1, CANES_SOFT_RESET_CONTROL_REG, 32'h0);
    {fs, cfg} = {CANES_FCS_CONFIG, 1'b1};
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    xfer(1'b0, CANES_ERROR_FLAG_REG, 32'h0);
    rd_stat();
    $display("test flags done");
    xfer(1'b1, CANES_SOFT_RESET_CONTROL_REG, 32'h2);
    fire(E_TX8, 3);
    xfer(1'b1, CANES_SOFT_RESET_CONTROL_REG, 32'h3);
    xfer(1'b0, CANES_SOFT_RESET_CONTROL_REG, 32'h0);
    xfer(1'b0, CANES_ERROR_COUNT_REG, cntw());
    rd_stat();
    fire(E_FUC, 1);
    fb = 1'b1;
    rd_stat();
    fire(E_FUD, 1);
    fb = 1'b0;
    rd_stat();
    xfer(1'b1, 8'h1C, $urandom);
    xfer(1'b0, 8'h1C, 32'h0);
    $display("test soft reset and filter done");
    end_of_test();
  end
endmodule

// ===== tb/canes_engine_model.sv
// Behavioural protocol engine: error events, bit samples and status levels for the block.
// Assumes every task is entered just after a rising edge of hclk.
`timescale 1ns/10ps
module canes_engine_model (
  input  wire logic        hclk,
  output logic      [11:0] ev,
  output logic             sample_strobe,
  output logic             sampled_bit,
  output logic             tx_active,
  output logic             tx_bit,
  output logic      [6:0]  lv
);
  initial begin
    ev            = 12'h000;
    sample_strobe = 1'b0;
    sampled_bit   = 1'b1;
    tx_active     = 1'b0;
    tx_bit        = 1'b1;
    lv            = 7'h00;
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  // pulses of the given event mask, each one cycle high then one cycle low
  task automatic fire(input logic [11:0] m, input int n);
    repeat (n) begin
      ev <= m;
      @(posedge hclk);
      ev <= 12'h000;
      @(posedge hclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Bit times
  // ----------------------------------------------------------------
  // Between strobes the sample lines flip, so a stale level is never mistaken for a bit.
  task automatic bits(input int n, input logic v, input logic drv, input logic txb);
    repeat (n) begin
      sample_strobe <= 1'b1;
      sampled_bit   <= v;
      tx_active     <= drv;
      tx_bit        <= txb;
      @(posedge hclk);
      sample_strobe <= 1'b0;
      sampled_bit   <= ~v;
      tx_bit        <= ~txb;
      @(posedge hclk);
    end
  endtask

  task automatic setlv();
    lv <= 7'($urandom);
    @(posedge hclk);
  endtask
endmodule
